// ---- hw/bdecr_top.sv ----
// register bank for second regulator dvs codes and third regulator enable/config
// Notes on behaviour
// RULE1: alt code 0 used on pair 00
// RULE2: alt code 1 used on pair 01
// RULE3: alt code 2 used on pair 10
// RULE4: alt code 3 used on pair 11
// RULE5: code maps to 550mV plus 25mV steps
// RULE6: read-only readback of code in effect
// RULE7: read-only sequence slot with boot timings
// RULE8: slot 111 hands over after full delay
// RULE9: enable select acts only under slot 111
// RULE10: config bit 7 disables integrator
// RULE11: config bit 6 power-good during transitions
// RULE12: config bit 5 fast transient mode
// RULE13: config bit 4 passive discharge when off
// RULE14: config bit 3 active discharge when off; code holds it off under slot 111 with select 00 except in hard reset
// RULE15: config bit 2 low emission edges
// RULE16: config bit 1 forces switch scaling
// RULE17: config bit 0 freewheel sense select
// RULE18: pair select field, zero disables dvs
// RULE19: pin control uses OR of selected inputs
// RULE20: first input is msb; reserved codes off
module bdecr_top (
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  output logic             reg_rvalid_out,
  input  wire logic [7:0]  multipurpose_ctrl_in,
  input  wire logic [2:0]  seq_strap_in,
  input  wire logic        hard_reset_in,
  output logic             buck2_dvs_active_out,
  output logic      [5:0]  buck2_dvs_code_out,
  output logic      [11:0] buck2_dvs_target_mv_out,
  output logic             buck3_enable_out,
  output logic             buck3_passive_discharge_out,
  output logic             buck3_active_discharge_out,
  output logic             integrator_disable_out,
  output logic             power_good_transition_enable_out,
  output logic             fast_transient_mode_out,
  output logic             low_emission_mode_out,
  output logic             switch_scaling_force_out,
  output logic             freewheel_sense_select_out
);
  // software registers
  logic [5:0] alt_code_q [4];
  logic [4:0] input_pair_select_q;
  logic [1:0] third_regulator_enable_select_q;
  logic [7:0] config_q;
  logic [7:0] third_regulator_input_select_bits_q;

  // strap capture and boot timing
  logic [2:0]             third_regulator_sequence_slot_q;
  logic                   strap_taken_q;
  logic [10:0]            boot_cnt_q;
  bdecr_pkg::bdecr_boot_t boot_phase_q;
  bdecr_pkg::bdecr_boot_t boot_phase_d;

  // output flops
  logic [7:0]  rdata_q;
  logic        rvalid_q;
  logic        dvs_active_q;
  logic [5:0]  dvs_code_q;
  logic [11:0] target_mv_q;
  logic        enable_q;
  logic        psv_dsc_q;
  logic        act_dsc_q;

  // address decode
  logic       wr_alt [4];
  logic       wr_pair;
  logic       wr_en_sel;
  logic       wr_cfg;
  logic       wr_in_sel;
  assign wr_alt[0] = reg_wr_in && (reg_addr_in == bdecr_pkg::ADDR_ALT_CODE_0);
  assign wr_alt[1] = reg_wr_in && (reg_addr_in == bdecr_pkg::ADDR_ALT_CODE_1);
  assign wr_alt[2] = reg_wr_in && (reg_addr_in == bdecr_pkg::ADDR_ALT_CODE_2);
  assign wr_alt[3] = reg_wr_in && (reg_addr_in == bdecr_pkg::ADDR_ALT_CODE_3);
  assign wr_pair   = reg_wr_in && (reg_addr_in == bdecr_pkg::ADDR_PAIR_SEL);
  assign wr_en_sel = reg_wr_in && (reg_addr_in == bdecr_pkg::ADDR_B3_ENABLE);
  assign wr_cfg    = reg_wr_in && (reg_addr_in == bdecr_pkg::ADDR_B3_CONFIG);
  assign wr_in_sel = reg_wr_in && (reg_addr_in == bdecr_pkg::ADDR_B3_IN_SEL);

  // dvs code selection
  logic       pair_active;
  logic [1:0] pair_code;
  logic [5:0] code_in_effect;
  logic [11:0] code_mv;

  bdecr_pair_sel u_pair_sel (
    .pair_sel_in (input_pair_select_q),
    .inputs_in   (multipurpose_ctrl_in),
    .active_out  (pair_active),
    .code_out    (pair_code)
  );

  // pair value indexes the four alternate codes directly
  assign code_in_effect = pair_active ? alt_code_q[pair_code] : 6'h00; // RULE1 RULE2 RULE3 RULE4
  assign code_mv        = bdecr_pkg::BASE_MV + 12'(bdecr_pkg::STEP_MV * 12'(code_in_effect)); // RULE5

  // third regulator enable decision
  logic pins_or;
  logic seq_enable;
  logic sw_enable;
  logic enable_d;
  logic en_sel_off;
  assign pins_or = |(multipurpose_ctrl_in & third_regulator_input_select_bits_q); // RULE19

  always_comb begin
    case (third_regulator_enable_select_q)
      bdecr_pkg::EN_OFF:  sw_enable = 1'b0;
      bdecr_pkg::EN_ON:   sw_enable = 1'b1;
      bdecr_pkg::EN_PINS: sw_enable = pins_or;
      default:            sw_enable = 1'b0; // RULE20
    endcase
  end

  always_comb begin
    case (third_regulator_sequence_slot_q)
      bdecr_pkg::SEQ_OFF: seq_enable = 1'b0; // RULE7
      bdecr_pkg::SEQ_P0:  seq_enable = strap_taken_q; // RULE7
      bdecr_pkg::SEQ_P25: seq_enable = (boot_phase_q != bdecr_pkg::BOOT_P0); // RULE7
      bdecr_pkg::SEQ_P50: seq_enable = (boot_phase_q == bdecr_pkg::BOOT_P50) ||
                                       (boot_phase_q == bdecr_pkg::BOOT_DONE); // RULE7
      bdecr_pkg::SEQ_SW:  seq_enable = (boot_phase_q == bdecr_pkg::BOOT_DONE) &&
                                       sw_enable; // RULE8 RULE9
      default:            seq_enable = 1'b0;
    endcase
  end

  assign enable_d   = seq_enable;
  // select 00 under software control keeps the active path quiet outside hard reset
  assign en_sel_off = (third_regulator_sequence_slot_q == bdecr_pkg::SEQ_SW) &&
                      (third_regulator_enable_select_q == bdecr_pkg::EN_OFF); // RULE9

  logic psv_dsc_d;
  logic act_dsc_d;

  bdecr_discharge u_psv_dsc (
    .hard_reset_in (hard_reset_in),
    .select_in     (config_q[bdecr_pkg::CFG_PSV_DSC]),
    .enable_in     (enable_q),
    .suppress_in   (1'b0),
    .discharge_out (psv_dsc_d)
  ); // RULE13

  bdecr_discharge u_act_dsc (
    .hard_reset_in (hard_reset_in),
    .select_in     (config_q[bdecr_pkg::CFG_ACT_DSC]),
    .enable_in     (enable_q),
    .suppress_in   (en_sel_off),
    .discharge_out (act_dsc_d)
  ); // RULE14

  // boot phase from a saturating counter started at reset release
  always_comb begin
    if (boot_cnt_q >= bdecr_pkg::BOOT_CYC_100) begin
      boot_phase_d = bdecr_pkg::BOOT_DONE;
    end else if (boot_cnt_q >= bdecr_pkg::BOOT_CYC_50) begin
      boot_phase_d = bdecr_pkg::BOOT_P50;
    end else if (boot_cnt_q >= bdecr_pkg::BOOT_CYC_25) begin
      boot_phase_d = bdecr_pkg::BOOT_P25;
    end else begin
      boot_phase_d = bdecr_pkg::BOOT_P0;
    end
  end

  // read mux; reserved bits and unmapped addresses read zero
  logic [7:0] rmux;
  always_comb begin
    case (reg_addr_in)
      bdecr_pkg::ADDR_PAIR_SEL:   rmux = {3'h0, input_pair_select_q};
      bdecr_pkg::ADDR_ALT_CODE_0: rmux = {2'h0, alt_code_q[0]};
      bdecr_pkg::ADDR_ALT_CODE_1: rmux = {2'h0, alt_code_q[1]};
      bdecr_pkg::ADDR_ALT_CODE_2: rmux = {2'h0, alt_code_q[2]};
      bdecr_pkg::ADDR_ALT_CODE_3: rmux = {2'h0, alt_code_q[3]};
      bdecr_pkg::ADDR_READBACK:   rmux = {2'h0, dvs_code_q}; // RULE6
      bdecr_pkg::ADDR_B3_ENABLE:  rmux = {third_regulator_sequence_slot_q, 3'h0,
                                          third_regulator_enable_select_q}; // RULE7
      bdecr_pkg::ADDR_B3_CONFIG:  rmux = config_q;
      bdecr_pkg::ADDR_B3_IN_SEL:  rmux = third_regulator_input_select_bits_q;
      default:                    rmux = 8'h00;
    endcase
  end

  // register writes; read-only fields ignore writes
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int k = 0; k < 4; k++) begin
        alt_code_q[k] <= bdecr_pkg::RST_ALT_CODE;
      end
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (wr_alt[k]) begin
          alt_code_q[k] <= reg_wdata_in[5:0]; // RULE1 RULE2 RULE3 RULE4
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      input_pair_select_q                 <= bdecr_pkg::RST_PAIR_SEL;
      third_regulator_enable_select_q     <= bdecr_pkg::RST_EN_SEL;
      config_q                            <= bdecr_pkg::RST_CONFIG;
      third_regulator_input_select_bits_q <= bdecr_pkg::RST_IN_SEL;
    end else begin
      if (wr_pair) begin
        input_pair_select_q <= reg_wdata_in[4:0]; // RULE18
      end
      if (wr_en_sel) begin
        third_regulator_enable_select_q <= reg_wdata_in[1:0]; // RULE9
      end
      if (wr_cfg) begin
        config_q <= reg_wdata_in;
      end
      if (wr_in_sel) begin
        third_regulator_input_select_bits_q <= reg_wdata_in;
      end
    end
  end

  // strap is sampled once, on the first edge after reset release
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      third_regulator_sequence_slot_q <= bdecr_pkg::SEQ_OFF;
      strap_taken_q                   <= 1'b0;
    end else if (!strap_taken_q) begin
      third_regulator_sequence_slot_q <= seq_strap_in; // RULE7
      strap_taken_q                   <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      boot_cnt_q   <= 11'h000;
      boot_phase_q <= bdecr_pkg::BOOT_P0;
    end else begin
      if (strap_taken_q && (boot_cnt_q < bdecr_pkg::BOOT_CYC_100)) begin
        boot_cnt_q <= boot_cnt_q + 11'h001;
      end
      boot_phase_q <= boot_phase_d;
    end
  end

  // registered outputs
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_q      <= 8'h00;
      rvalid_q     <= 1'b0;
      dvs_active_q <= 1'b0;
      dvs_code_q   <= 6'h00;
      target_mv_q  <= 12'h000;
      enable_q     <= 1'b0;
      psv_dsc_q    <= 1'b0;
      act_dsc_q    <= 1'b0;
    end else begin
      rdata_q      <= reg_rd_in ? rmux : rdata_q;
      rvalid_q     <= reg_rd_in;
      dvs_active_q <= pair_active; // RULE18
      dvs_code_q   <= code_in_effect; // RULE6
      target_mv_q  <= code_mv; // RULE5
      enable_q     <= enable_d;
      psv_dsc_q    <= psv_dsc_d;
      act_dsc_q    <= act_dsc_d;
    end
  end

  assign reg_rdata_out               = rdata_q;
  assign reg_rvalid_out              = rvalid_q;
  assign buck2_dvs_active_out        = dvs_active_q;
  assign buck2_dvs_code_out          = dvs_code_q;
  assign buck2_dvs_target_mv_out     = target_mv_q;
  assign buck3_enable_out            = enable_q;
  assign buck3_passive_discharge_out = psv_dsc_q;
  assign buck3_active_discharge_out  = act_dsc_q;

  // operating mode bits go straight from the config flops
  assign integrator_disable_out           = config_q[bdecr_pkg::CFG_INTEG_DIS]; // RULE10
  assign power_good_transition_enable_out = config_q[bdecr_pkg::CFG_POWER_GOOD_COMPARATOR_TRAN]; // RULE11
  assign fast_transient_mode_out          = config_q[bdecr_pkg::CFG_FAST]; // RULE12
  assign low_emission_mode_out            = config_q[bdecr_pkg::CFG_LOW_EMI]; // RULE15
  assign switch_scaling_force_out         = config_q[bdecr_pkg::CFG_FET_SCALE]; // RULE16
  // software must keep this clear at low output settings; not enforced here
  assign freewheel_sense_select_out       = config_q[bdecr_pkg::CFG_LX_SENSE]; // RULE17
endmodule

// ---- pkg/bdecr_pkg.sv ----
// constants for the second/third regulator dvs, enable and config register bank
package bdecr_pkg;
  localparam logic [7:0] ADDR_PAIR_SEL   = 8'h2D;
  localparam logic [7:0] ADDR_ALT_CODE_0 = 8'h2E;
  localparam logic [7:0] ADDR_ALT_CODE_1 = 8'h2F;
  localparam logic [7:0] ADDR_ALT_CODE_2 = 8'h30;
  localparam logic [7:0] ADDR_ALT_CODE_3 = 8'h31;
  localparam logic [7:0] ADDR_READBACK   = 8'h32;
  localparam logic [7:0] ADDR_B3_ENABLE  = 8'h34;
  localparam logic [7:0] ADDR_B3_CONFIG  = 8'h35;
  localparam logic [7:0] ADDR_B3_IN_SEL  = 8'h39;

  localparam int CODE_W     = 6;
  localparam int PAIR_SEL_W = 5;
  localparam int INPUTS_N   = 8;
  localparam int SEQ_LSB    = 5;
  localparam int MV_W       = 12;

  localparam logic [5:0]  RST_ALT_CODE = 6'h00;
  localparam logic [4:0]  RST_PAIR_SEL = 5'h00;
  localparam logic [1:0]  RST_EN_SEL   = 2'h0;
  localparam logic [7:0]  RST_CONFIG   = 8'h00;
  localparam logic [7:0]  RST_IN_SEL   = 8'h00;

  // config byte bit positions
  localparam int CFG_INTEG_DIS  = 7;
  localparam int CFG_POWER_GOOD_COMPARATOR_TRAN = 6;
  localparam int CFG_FAST       = 5;
  localparam int CFG_PSV_DSC    = 4;
  localparam int CFG_ACT_DSC    = 3;
  localparam int CFG_LOW_EMI    = 2;
  localparam int CFG_FET_SCALE  = 1;
  localparam int CFG_LX_SENSE   = 0;

  // sequence slot codes
  localparam logic [2:0] SEQ_OFF = 3'h0;
  localparam logic [2:0] SEQ_P0  = 3'h2;
  localparam logic [2:0] SEQ_P25 = 3'h3;
  localparam logic [2:0] SEQ_P50 = 3'h4;
  localparam logic [2:0] SEQ_SW  = 3'h7;

  // enable select codes
  localparam logic [1:0] EN_OFF  = 2'h0;
  localparam logic [1:0] EN_ON   = 2'h1;
  localparam logic [1:0] EN_PINS = 2'h2;

  // linear voltage map in millivolts
  localparam logic [11:0] BASE_MV = 12'h226;
  localparam logic [11:0] STEP_MV = 12'h019;

  // boot delay; value is a plain default
  localparam int CLK_MHZ       = 100;
  localparam int BOOT_DELAY_US = 10;
  localparam int BOOT_CYC      = BOOT_DELAY_US * CLK_MHZ;
  localparam int BOOT_CNT_W    = 11;
  localparam logic [10:0] BOOT_CYC_25  = 11'(BOOT_CYC / 4);
  localparam logic [10:0] BOOT_CYC_50  = 11'(BOOT_CYC / 2);
  localparam logic [10:0] BOOT_CYC_100 = 11'(BOOT_CYC);

  typedef enum logic [1:0] {
    BOOT_P0   = 2'b00,
    BOOT_P25  = 2'b01,
    BOOT_P50  = 2'b10,
    BOOT_DONE = 2'b11
  } bdecr_boot_t;
endpackage

// ---- hw/bdecr_pair_sel.sv ----
// picks the controlling input pair for the second regulator and forms the two-bit code
module bdecr_pair_sel (
  input  wire logic [4:0] pair_sel_in,
  input  wire logic [7:0] inputs_in,
  output logic            active_out,
  output logic [1:0]      code_out
);
  logic [2:0] first_idx;
  logic [2:0] second_idx;
  logic       found;

  // codes 1..28 walk the pairs (i,j), i<j, in order; the rest disable
  always_comb begin
    logic [4:0] n;
    n          = 5'h01;
    first_idx  = 3'h0;
    second_idx = 3'h0;
    found      = 1'b0;
    for (int i = 0; i < bdecr_pkg::INPUTS_N; i++) begin
      for (int j = i + 1; j < bdecr_pkg::INPUTS_N; j++) begin
        if (n == pair_sel_in) begin
          first_idx  = 3'(i);
          second_idx = 3'(j);
          found      = 1'b1;
        end
        n = n + 5'h01;
      end
    end
  end

  assign active_out = found; // RULE18
  assign code_out   = {inputs_in[first_idx], inputs_in[second_idx]}; // RULE20
endmodule

// ---- hw/bdecr_discharge.sv ----
// discharge request for one discharge path of the third regulator
module bdecr_discharge (
  input  wire logic hard_reset_in,
  input  wire logic select_in,
  input  wire logic enable_in,
  input  wire logic suppress_in,
  output logic      discharge_out
);
  // hard reset always discharges; enable-low only when selected
  assign discharge_out = hard_reset_in | (select_in & ~enable_in & ~suppress_in);
endmodule

// ---- testbench/bdecr_host_model.sv ----
// host processor model driving the multipurpose control inputs
module bdecr_host_model (
  input  wire logic       clk_sys_in,
  input  wire logic [7:0] level_in,
  input  wire logic       slow_in,
  output logic      [7:0] ctrl_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] lag_q = 2'h0;
  initial ctrl_out = 8'h00;
  // a slow host lets a new level land two cycles late
  always @(posedge clk_sys_in) begin
    if (level_in == ctrl_out || !slow_in || lag_q == 2'h2) begin
      ctrl_out <= level_in;
      lag_q    <= 2'h0;
    end else begin
      lag_q <= lag_q + 2'h1;
    end
  end
endmodule

// ---- testbench/bdecr_assertions.sv ----
// concurrent checks on the regulator register bank ports
module bdecr_checker (
  input wire logic        clk_sys_in,
  input wire logic        rstn_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic        reg_rvalid_out,
  input wire logic [7:0]  multipurpose_ctrl_in,
  input wire logic [2:0]  seq_strap_in,
  input wire logic        hard_reset_in,
  input wire logic        buck2_dvs_active_out,
  input wire logic [5:0]  buck2_dvs_code_out,
  input wire logic [11:0] buck2_dvs_target_mv_out,
  input wire logic        buck3_enable_out,
  input wire logic        buck3_passive_discharge_out,
  input wire logic        buck3_active_discharge_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  logic        first_q;
  logic [2:0]  slot_q;
  logic [10:0] cnt_q;
  logic [10:0] due;
  logic        timed;
  // own copy of the strap, taken on the same edge as the design's
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      first_q <= 1'b1;
      slot_q  <= 3'h0;
      cnt_q   <= 11'h000;
    end else begin
      first_q <= 1'b0;
      slot_q  <= first_q ? seq_strap_in : slot_q;
      cnt_q   <= (cnt_q == 11'h7FF) ? cnt_q : cnt_q + 11'h001;
    end
  end
  assign due   = (slot_q == 3'h3) ? 11'h0FA : (slot_q == 3'h4) ? 11'h1F4 : 11'h000;
  assign timed = (slot_q == 3'h2) || (slot_q == 3'h3) || (slot_q == 3'h4);

  rvalid_pulse_a: assert property ($past(rstn_in) |-> reg_rvalid_out == $past(reg_rd_in))
    else $error("read valid not one cycle after strobe");
  target_map_a: assert property ($past(rstn_in) |->
    buck2_dvs_target_mv_out == 12'h226 + 12'h019 * 12'(buck2_dvs_code_out))
    else $error("target millivolts off the linear map");
  dvs_off_a: assert property (!buck2_dvs_active_out |-> buck2_dvs_code_out == 6'h00)
    else $error("code not zero with dvs off");
  code_hold_a: assert property ($past(rstn_in) && !reg_wr_in && !$past(reg_wr_in) &&
    $stable(multipurpose_ctrl_in) |=> $stable(buck2_dvs_code_out))
    else $error("dvs code moved without cause");
  hard_discharge_a: assert property (hard_reset_in |=>
    buck3_passive_discharge_out && buck3_active_discharge_out)
    else $error("no discharge in hard reset");
  no_discharge_a: assert property (buck3_enable_out && !hard_reset_in |=>
    !buck3_passive_discharge_out && !buck3_active_discharge_out)
    else $error("discharge while enabled");
  slot_off_a: assert property (!first_q && !timed && slot_q != 3'h7 |-> !buck3_enable_out)
    else $error("enabled with slot off or reserved");
  boot_early_a: assert property (timed && cnt_q + 11'h004 < due |-> !buck3_enable_out)
    else $error("enabled before its boot phase");
  boot_late_a: assert property (timed && cnt_q > due + 11'h008 |-> buck3_enable_out)
    else $error("not enabled after its boot phase");
  sw_wait_a: assert property (slot_q == 3'h7 && cnt_q < 11'h3DE |-> !buck3_enable_out)
    else $error("software control before full boot delay");

  cover property (buck2_dvs_code_out == 6'h3F);
  cover property (buck3_enable_out && slot_q == 3'h7);
  cover property (hard_reset_in ##1 buck3_active_discharge_out);
endmodule

// ---- testbench/bdecr_top_tb.sv ----
// self-checking bench for the regulator register bank
module bdecr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_in = 1'b0;
  logic        rstn_in    = 1'b0;
  logic [7:0]  addr       = 8'h00;
  logic [7:0]  wdata      = 8'h00;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic [7:0]  level      = 8'h00;
  logic        slow       = 1'b0;
  logic [2:0]  strap      = 3'h7;
  logic        hard       = 1'b0;
  logic [7:0]  multipurpose_control_input;
  logic [7:0]  rdata;
  logic        rvalid;
  logic        dvs_on;
  logic        b3_en;
  logic        psv;
  logic        act;
  logic [5:0]  code;
  logic [11:0] mv;
  logic [5:0]  cfg_o;
  logic [7:0]  pat;
  logic [11:0] exp_v;
  int          n_errors   = 0;
  int          n_compared = 0;
  int          cyc        = 0;
  logic [5:0]  alt [4]  = '{6'h05, 6'h2A, 6'h14, 6'h3F};
  logic [7:0]  regs [9] = '{8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h31, 8'h32, 8'h33, 8'h35, 8'h39};
  logic [1:0]  sel_t [7] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h3};
  logic [7:0]  lvl_t [7] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h01, 8'h02, 8'hFF};
  logic        en_t [7]  = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [2:0]  straps [5] = '{3'h2, 3'h3, 3'h4, 3'h0, 3'h5};

  bdecr_host_model i_bdecr_host_model (.clk_sys_in(clk_sys_in), .level_in(level),
    .slow_in(slow), .ctrl_out(multipurpose_control_input));
  bdecr_top i_bdecr_top (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .multipurpose_ctrl_in(multipurpose_control_input), .seq_strap_in(strap),
    .hard_reset_in(hard), .buck2_dvs_active_out(dvs_on), .buck2_dvs_code_out(code),
    .buck2_dvs_target_mv_out(mv), .buck3_enable_out(b3_en),
    .buck3_passive_discharge_out(psv), .buck3_active_discharge_out(act),
    .integrator_disable_out(cfg_o[5]), .power_good_transition_enable_out(cfg_o[4]),
    .fast_transient_mode_out(cfg_o[3]), .low_emission_mode_out(cfg_o[2]),
    .switch_scaling_force_out(cfg_o[1]), .freewheel_sense_select_out(cfg_o[0]));

  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1;
    chk({3'h0, rvalid, rdata}, {4'h1, exp}, "read data");
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic restart(input logic [2:0] s);
    @(posedge clk_sys_in);
    rstn_in <= 1'b0;
    strap   <= s;
    repeat (16) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
  endtask
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // generous ceiling: the sequence needs a little over four thousand cycles
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    restart(3'h7);
    foreach (regs[i]) rd_reg(regs[i], 8'h00);
    rd_reg(8'h34, 8'hE0);
    foreach (alt[i]) wr_reg(8'h2E + 8'(i), {2'h3, alt[i]});
    foreach (alt[i]) rd_reg(8'h2E + 8'(i), {2'h0, alt[i]});
    wr_reg(8'h32, 8'hFF);
    rd_reg(8'h32, 8'h00);
    wr_reg(8'h34, 8'hFD);
    rd_reg(8'h34, 8'hE1);
    settle(300);
    chk(12'(b3_en), 12'h000, "enable before boot delay");
    $display("test registers done");
    wr_reg(8'h2D, 8'h01);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys_in);
      level <= {6'h00, m[0], m[1]};
      slow  <= m[0];
      settle(6);
      chk(12'({dvs_on, code}), 12'({1'b1, alt[m]}), "dvs code");
      chk(mv, 12'h226 + 12'h019 * alt[m], "target mv");
      rd_reg(8'h32, {2'h0, alt[m]});
    end
    wr_reg(8'h2D, 8'h1C);
    @(posedge clk_sys_in);
    level <= 8'h40;
    settle(6);
    chk(12'(code), 12'(alt[2]), "last pair");
    wr_reg(8'h2D, 8'h00);
    settle(3);
    chk(12'({dvs_on, code}), 12'h000, "dvs off");
    chk(mv, 12'h226, "dvs off target");
    wr_reg(8'h2D, 8'h1D);
    settle(3);
    chk(12'(dvs_on), 12'h000, "reserved pair");
    $display("test dvs done");
    settle(700);
    wr_reg(8'h39, 8'h81);
    for (int i = 0; i < 7; i++) begin
      wr_reg(8'h34, {6'h00, sel_t[i]});
      level <= lvl_t[i];
      settle(6);
      chk(12'(b3_en), 12'(en_t[i]), "enable select");
    end
    for (int b = 0; b < 8; b++) begin
      pat = 8'h01 << b;
      exp_v = 12'({pat[7:5], pat[2:0]});
      wr_reg(8'h35, pat);
      settle(3);
      chk(12'(cfg_o), exp_v, "config");
      chk(12'({psv, act}), 12'(pat[4:3]), "discharge");
    end
    wr_reg(8'h35, 8'h00);
    @(posedge clk_sys_in);
    hard <= 1'b1;
    settle(3);
    chk(12'({psv, act}), 12'h003, "hard reset discharge");
    @(posedge clk_sys_in);
    hard <= 1'b0;
    wr_reg(8'h34, 8'h00);
    wr_reg(8'h35, 8'h08);
    settle(3);
    chk(12'({psv, act}), 12'h000, "select off discharge");
    $display("test third regulator done");
    foreach (straps[i]) begin
      restart(straps[i]);
      settle(200);
      chk(12'(b3_en), 12'(straps[i] == 3'h2), "early phase");
      settle(400);
      chk(12'(b3_en), 12'(straps[i] >= 3'h2 && straps[i] <= 3'h4), "late phase");
      rd_reg(8'h34, {straps[i], 5'h00});
    end
    $display("test boot slots done");
    summarize();
  end
endmodule

bind bdecr_top bdecr_checker i_bdecr_checker (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rvalid_out(reg_rvalid_out),
  .multipurpose_ctrl_in(multipurpose_ctrl_in), .seq_strap_in(seq_strap_in),
  .hard_reset_in(hard_reset_in), .buck2_dvs_active_out(buck2_dvs_active_out),
  .buck2_dvs_code_out(buck2_dvs_code_out), .buck2_dvs_target_mv_out(buck2_dvs_target_mv_out),
  .buck3_enable_out(buck3_enable_out),
  .buck3_passive_discharge_out(buck3_passive_discharge_out),
  .buck3_active_discharge_out(buck3_active_discharge_out));
